//--- design/scc_pkg.sv
// Package: register map, field layout, reset values and carriers of the converter control
`default_nettype none
package scc_pkg;

   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] ADR_CTRL1            = 8'h00;
   localparam logic [7:0] ADR_CTRL2            = 8'h04;
   localparam logic [7:0] ADR_CTRL3            = 8'h08;
   localparam logic [7:0] ADR_STATUS           = 8'h0c;
   localparam logic [7:0] ADR_RESULT_HIGH      = 8'h10;
   localparam logic [7:0] ADR_RESULT_LOW       = 8'h14;
   localparam logic [7:0] ADR_COMPARE          = 8'h18;
   localparam logic [7:0] ADR_PIN_CONTROL_LOW  = 8'h1c;
   localparam logic [7:0] ADR_PIN_CONTROL_HIGH = 8'h20;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int CH_LSB      = 0;   // channel_select [4:0]
   localparam int CONT_BIT    = 5;   // continuous conversion
   localparam int IRQEN_BIT   = 6;   // complete_irq_enable
   localparam int CMPEN_BIT   = 0;   // compare_enable
   localparam int CMPGE_BIT   = 1;   // compare greater-or-equal
   localparam int HWTRG_BIT   = 2;   // hardware trigger enable
   localparam int ICLK_LSB    = 0;   // input_clock_select [1:0]
   localparam int MODE_LSB    = 2;   // resolution [3:2]
   localparam int LSMP_BIT    = 4;   // long_sample_select
   localparam int DIV_LSB     = 5;   // clock_divide_select [6:5]
   localparam int FLAG_BIT    = 0;   // conversion_complete_flag
   localparam int MATCH_BIT   = 1;   // last compare matched
   localparam int BUSY_BIT    = 2;   // conversion in progress

   // -----------------------------------------------------------------
   // Masks and reset values
   // -----------------------------------------------------------------
   localparam logic [31:0] MASK_CTRL1  = 32'h0000_007f;
   localparam logic [31:0] MASK_CTRL2  = 32'h0000_0007;
   localparam logic [31:0] MASK_CTRL3  = 32'h0000_007f;
   localparam logic [31:0] MASK_CMP    = 32'h0000_0fff;
   localparam logic [31:0] MASK_PCL    = 32'h0000_ffff;
   localparam logic [31:0] MASK_PCH    = 32'h0000_00ff;
   localparam logic [31:0] RST_CTRL1   = 32'h0000_001f;
   localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
   localparam logic [4:0]  CH_DISABLED = 5'h1f;

   // -----------------------------------------------------------------
   // Encodings and timing counts (conversion clock cycles)
   // -----------------------------------------------------------------
   localparam logic [1:0] RES_8      = 2'h0;
   localparam logic [1:0] RES_12     = 2'h1;
   localparam logic [1:0] RES_10     = 2'h2;
   localparam logic [1:0] CLK_BUS    = 2'h0;
   localparam logic [1:0] CLK_BUS_2  = 2'h1;
   localparam logic [1:0] CLK_ALT    = 2'h2;
   localparam logic [1:0] CLK_ASYNC  = 2'h3;
   localparam int SAMPLE_SHORT_HALVES = 7;    // 3.5 cycles
   localparam int SAMPLE_LONG_HALVES  = 47;   // 23.5 cycles
   localparam logic [4:0] SAMPLE_SHORT_CYC = 5'((SAMPLE_SHORT_HALVES + 1) / 2);
   localparam logic [4:0] SAMPLE_LONG_CYC  = 5'((SAMPLE_LONG_HALVES + 1) / 2);
   localparam int SAR_BITS = 12;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT,
      ST_STORE
   } scc_state_t;

   // Drive towards the analog core
   typedef struct packed {
      logic        power_up;
      logic        sample;
      logic        async_clk_enable;
      logic [4:0]  channel;
      logic [11:0] dac_code;
   } scc_analog_t;

   // Pin forcing, one bit per analog input
   typedef struct packed {
      logic [23:0] output_hiz;
      logic [23:0] input_disable;
      logic [23:0] pullup_disable;
   } scc_pins_t;

endpackage
`default_nettype wire

//--- design/scc_sar_converter_control.sv
// Control logic of the successive-approximation converter with its Wishbone register file
//
// Contract
// - Converter disabled in reset and while channel field is all ones.
// - After a conversion, converter idles in lowest power until restarted.
// - Resolution selects 12, 10 or 8 bit result for selected channel.
// - 10-bit rounded across both result registers; 8-bit rounded into low only.
// - Results right-justified, unsigned, at every resolution.
// - Stored result sets complete flag; interrupt if enable set then.
// - Compare enable compares every result against compare value.
// - Compare supports less-than and greater-or-equal, interrupt on match.
// - Clock select picks bus, bus halved, alternate or internal async clock.
// - Clock select resets to undivided bus clock.
// - Bus halved with divider reaches bus clock divided by 16.
// - Internal async clock keeps running in wait and stop modes.
// - Divider divides selected source by 1, 2, 4 or 8.
// - Pin-control bit forces that pin's output buffer high impedance.
// - Pin-control bit disables input buffer; port read gives zero.
// - Pin-control bit disables that pin's pull-up.
// - Channel field selects among up to 24 analog inputs.
// - Hardware trigger rising edge starts conversion; ignored while busy.
// - Continuous mode restarts conversion as soon as one completes.
// - Long sample bit selects 3.5 or 23.5 conversion-clock sample phase; the code samples for 4 or 24 conversion clocks.
// - Abort keeps last results; reset returns them to reset values.
//
// Added by the designer: register access over Wishbone and the address map.
`default_nettype none
module scc_sar_converter_control
   import scc_pkg::*;
#(
   parameter int unsigned CHANNELS = 24
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        comparator_i,
   input  wire logic        alternate_clock_i,
   input  wire logic        internal_async_clock_i,
   input  wire logic        hw_trigger_input_i,
   input  wire logic        stop_mode_i,
   input  wire logic [23:0] port_pins_i,
   output scc_analog_t      analog_o,
   output scc_pins_t        pins_o,
   output logic      [23:0] port_read_o,
   output logic             irq_o
);

   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   logic [31:0] ctrl1;
   logic [31:0] ctrl2;
   logic [31:0] ctrl3;
   logic [31:0] compare_value;
   logic [31:0] pin_control_low;
   logic [31:0] pin_control_high;
   logic [7:0]  result_high;
   logic [7:0]  result_low;
   logic        conversion_complete_flag;
   logic        compare_match;
   logic        irq_pending;
   scc_state_t  state;
   logic [4:0]  phase_cnt;
   logic [3:0]  bit_idx;
   logic [11:0] sar;
   logic [2:0]  div_cnt;
   logic        half_tog;
   logic [2:0]  alt_sync;
   logic [2:0]  async_sync;
   logic [2:0]  trig_sync;
   logic [1:0]  stop_sync;
   logic [23:0] port_s1;
   logic [23:0] port_s2;

   // ----------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------
   logic [4:0] channel_select;
   logic       continuous;
   logic       complete_irq_enable;
   logic       compare_enable;
   logic       compare_gte;
   logic       hw_trigger_enable;
   logic [1:0] input_clock_select;
   logic [1:0] resolution;
   logic       long_sample_select;
   logic [1:0] clock_divide_select;
   logic [23:0] pin_control;

   assign channel_select      = ctrl1[CH_LSB +: 5];
   assign continuous          = ctrl1[CONT_BIT];
   assign complete_irq_enable = ctrl1[IRQEN_BIT];
   assign compare_enable      = ctrl2[CMPEN_BIT];
   assign compare_gte         = ctrl2[CMPGE_BIT];
   assign hw_trigger_enable   = ctrl2[HWTRG_BIT];
   assign input_clock_select  = ctrl3[ICLK_LSB +: 2];
   assign resolution          = ctrl3[MODE_LSB +: 2];
   assign long_sample_select  = ctrl3[LSMP_BIT];
   assign clock_divide_select = ctrl3[DIV_LSB +: 2];
   assign pin_control         = {pin_control_high[7:0], pin_control_low[15:0]};

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   logic        bus_req;
   logic        bus_wr;
   logic        bus_rd;
   logic [31:0] rd_data;

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr  = bus_req && wb_we_i;
   assign bus_rd  = bus_req && !wb_we_i;

   function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel, input logic [31:0] mask);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r & mask;
   endfunction

   logic        wr_ctrl1;
   logic        wr_abort;
   logic [31:0] next_ctrl1;
   logic [31:0] next_ctrl2;

   assign wr_ctrl1   = bus_wr && wb_adr_i == ADR_CTRL1;
   assign wr_abort   = bus_wr && (wb_adr_i == ADR_CTRL1 || wb_adr_i == ADR_CTRL2 ||
                                  wb_adr_i == ADR_CTRL3 || wb_adr_i == ADR_COMPARE);
   assign next_ctrl1 = merge(ctrl1, wb_dat_i, wb_sel_i, MASK_CTRL1);
   assign next_ctrl2 = (bus_wr && wb_adr_i == ADR_CTRL2) ? merge(ctrl2, wb_dat_i, wb_sel_i, MASK_CTRL2)
                                                          : ctrl2;

   always_comb begin
      unique case (wb_adr_i)
         ADR_CTRL1:            rd_data = ctrl1;
         ADR_CTRL2:            rd_data = ctrl2;
         ADR_CTRL3:            rd_data = ctrl3;
         ADR_STATUS:           rd_data = {29'h0, state != ST_IDLE, compare_match, conversion_complete_flag};
         ADR_RESULT_HIGH:      rd_data = {24'h0, result_high};
         ADR_RESULT_LOW:       rd_data = {24'h0, result_low};
         ADR_COMPARE:          rd_data = compare_value;
         ADR_PIN_CONTROL_LOW:  rd_data = pin_control_low;
         ADR_PIN_CONTROL_HIGH: rd_data = pin_control_high;
         default:              rd_data = 32'h0;
      endcase
   end

   // Every access is acknowledged one cycle later; unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_rd ? rd_data : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl1            <= RST_CTRL1;
         ctrl2            <= RST_ZERO;
         ctrl3            <= RST_ZERO;
         compare_value    <= RST_ZERO;
         pin_control_low  <= RST_ZERO;
         pin_control_high <= RST_ZERO;
      end else if (bus_wr) begin
         unique case (wb_adr_i)
            ADR_CTRL1:            ctrl1            <= next_ctrl1;
            ADR_CTRL2:            ctrl2            <= next_ctrl2;
            ADR_CTRL3:            ctrl3            <= merge(ctrl3, wb_dat_i, wb_sel_i, MASK_CTRL3);
            ADR_COMPARE:          compare_value    <= merge(compare_value, wb_dat_i, wb_sel_i, MASK_CMP);
            ADR_PIN_CONTROL_LOW:  pin_control_low  <= merge(pin_control_low, wb_dat_i, wb_sel_i, MASK_PCL);
            ADR_PIN_CONTROL_HIGH: pin_control_high <= merge(pin_control_high, wb_dat_i, wb_sel_i, MASK_PCH);
            default:              ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Synchronisers for pins and foreign clocks
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alt_sync   <= 3'h0;
         async_sync <= 3'h0;
         trig_sync  <= 3'h0;
         stop_sync  <= 2'h0;
         port_s1    <= 24'h0;
         port_s2    <= 24'h0;
      end else begin
         alt_sync   <= {alt_sync[1:0], alternate_clock_i};
         async_sync <= {async_sync[1:0], internal_async_clock_i};
         trig_sync  <= {trig_sync[1:0], hw_trigger_input_i};
         stop_sync  <= {stop_sync[0], stop_mode_i};
         port_s1    <= port_pins_i;
         port_s2    <= port_s1;
      end
   end

   logic alt_rise;
   logic async_rise;
   logic trig_rise;

   assign alt_rise   = alt_sync[1] && !alt_sync[2];
   assign async_rise = async_sync[1] && !async_sync[2];
   assign trig_rise  = trig_sync[1] && !trig_sync[2];

   // ----------------------------------------------------------------
   // Conversion clock enable
   // ----------------------------------------------------------------
   // A single clock domain avoids a gated or generated clock tree
   logic       src_tick;
   logic       conversion_clock_tick;
   logic [2:0] div_last;

   always_comb begin
      unique case (input_clock_select)
         CLK_BUS:   src_tick = 1'b1;
         CLK_BUS_2: src_tick = half_tog;
         CLK_ALT:   src_tick = alt_rise;
         CLK_ASYNC: src_tick = async_rise;
      endcase
   end

   assign div_last  = 3'((4'h1 << clock_divide_select) - 4'h1);
   assign conversion_clock_tick = src_tick && div_cnt == div_last;

   always_ff @(posedge clk_i) begin
      if (rst_i || state == ST_IDLE) begin
         div_cnt  <= 3'h0;
         half_tog <= 1'b0;
      end else begin
         half_tog <= !half_tog;
         if (src_tick) begin
            div_cnt <= conversion_clock_tick ? 3'h0 : div_cnt + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Result formatting
   // ----------------------------------------------------------------
   logic [12:0] sum10;
   logic [12:0] sum8;
   logic [11:0] formatted;
   logic        match_now;

   assign sum10 = {1'b0, sar} + 13'h2;
   assign sum8  = {1'b0, sar} + 13'h8;

   always_comb begin
      unique case (resolution)
         RES_10:  formatted = sum10[12] ? 12'h3ff : {2'h0, sum10[11:2]};
         RES_8:   formatted = sum8[12] ? 12'h0ff : {4'h0, sum8[11:4]};
         default: formatted = sar;
      endcase
   end

   assign match_now = compare_gte ? (formatted >= compare_value[11:0]) : (formatted < compare_value[11:0]);

   // ----------------------------------------------------------------
   // Conversion sequencer
   // ----------------------------------------------------------------
   logic start_sw;
   logic start_hw;
   logic abort;
   logic store_ok;

   assign start_sw = wr_ctrl1 && next_ctrl1[CH_LSB +: 5] != CH_DISABLED && !next_ctrl2[HWTRG_BIT];
   assign start_hw = trig_rise && hw_trigger_enable && state == ST_IDLE &&
                     channel_select != CH_DISABLED && !wr_abort;
   // Stop without the internal clock cannot continue
   assign abort    = wr_abort || (stop_sync[1] && input_clock_select != CLK_ASYNC);
   assign store_ok = !compare_enable || match_now;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state     <= ST_IDLE;
         phase_cnt <= 5'h0;
         bit_idx   <= 4'h0;
         sar       <= 12'h0;
      end else if (abort) begin
         state     <= start_sw ? ST_SAMPLE : ST_IDLE;
         phase_cnt <= 5'h0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start_hw) begin
                  state     <= ST_SAMPLE;
                  phase_cnt <= 5'h0;
               end
            end
            ST_SAMPLE: begin
               if (conversion_clock_tick) begin
                  phase_cnt <= phase_cnt + 5'h1;
                  if (phase_cnt == (long_sample_select ? SAMPLE_LONG_CYC : SAMPLE_SHORT_CYC) - 5'h1) begin
                     state   <= ST_CONVERT;
                     bit_idx <= 4'(SAR_BITS - 1);
                     sar     <= 12'h800;
                  end
               end
            end
            ST_CONVERT: begin
               if (conversion_clock_tick && analog_o.dac_code == sar) begin
                  // Core must show this trial code first; comparator high keeps the bit
                  sar[bit_idx] <= comparator_i;
                  if (bit_idx == 4'h0) begin
                     state <= ST_STORE;
                  end else begin
                     sar[bit_idx - 4'h1] <= 1'b1;
                     bit_idx             <= bit_idx - 4'h1;
                  end
               end
            end
            ST_STORE: begin
               phase_cnt <= 5'h0;
               state     <= continuous ? ST_SAMPLE : ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Results, flags and interrupt
   // ----------------------------------------------------------------
   logic do_store;
   logic flag_clear;

   assign do_store   = !abort && state == ST_STORE && store_ok;
   assign flag_clear = wr_ctrl1 || (bus_rd && wb_adr_i == ADR_RESULT_LOW);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_high <= 8'h0;
         result_low  <= 8'h0;
      end else if (do_store) begin
         result_high <= {4'h0, formatted[11:8]};
         result_low  <= formatted[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conversion_complete_flag <= 1'b0;
         compare_match            <= 1'b0;
         irq_pending              <= 1'b0;
      end else begin
         // Set wins over a clear in the same cycle
         if (do_store) begin
            conversion_complete_flag <= 1'b1;
            compare_match            <= compare_enable;
            irq_pending              <= complete_irq_enable;
         end else if (flag_clear) begin
            conversion_complete_flag <= 1'b0;
            compare_match            <= 1'b0;
            irq_pending              <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o       <= 1'b0;
         analog_o    <= '0;
         pins_o      <= '0;
         port_read_o <= 24'h0;
      end else begin
         irq_o                     <= irq_pending;
         analog_o.power_up         <= state != ST_IDLE;
         analog_o.sample           <= state == ST_SAMPLE;
         analog_o.async_clk_enable <= state != ST_IDLE && input_clock_select == CLK_ASYNC;
         analog_o.channel          <= channel_select;
         analog_o.dac_code         <= sar;
         pins_o.output_hiz         <= pin_control;
         pins_o.input_disable      <= pin_control;
         pins_o.pullup_disable     <= pin_control;
         port_read_o               <= port_s2 & ~pin_control;
      end
   end

endmodule
`default_nettype wire

//--- tb/scc_core_model.sv
// Analog core stand-in: comparator of a fixed input level against the trial code
`default_nettype none
module scc_core_model
   import scc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire scc_analog_t analog_i,
   input  wire logic [11:0] level_i,
   output logic             comparator_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic toggle = 1'b0;
   always_ff @(posedge clk_i) toggle <= ~toggle;
   // Unpowered core gives no stable answer, so the output wanders
   always_comb begin
      if (analog_i.power_up) begin
         comparator_o = (level_i >= analog_i.dac_code);
      end else begin
         comparator_o = toggle;
      end
   end
endmodule
`default_nettype wire

//--- tb/scc_sar_converter_control_assertions.sv
// Checker: bus handshake, pin forcing and start conditions of the converter control
`default_nettype none
module scc_sar_converter_control_assertions
   import scc_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire scc_analog_t analog_o,
   input wire scc_pins_t   pins_o,
   input wire logic [23:0] port_read_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   a_ack_after_req: assert property (req |=> wb_ack_o) else $error("ack missing after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   a_pin_write: assert property (req && wb_we_i && wb_adr_i == ADR_PIN_CONTROL_LOW && wb_sel_i == 4'hf
      |-> ##2 pins_o.output_hiz[15:0] == $past(wb_dat_i[15:0], 2)) else $error("pin control not applied");
   a_pullup_off: assert property (req && wb_we_i && wb_adr_i == ADR_PIN_CONTROL_HIGH && wb_sel_i == 4'hf
      |-> ##2 pins_o.pullup_disable[23:16] == $past(wb_dat_i[7:0], 2)) else $error("pullup forcing missing");
   a_input_off: assert property (req && wb_we_i && wb_adr_i == ADR_PIN_CONTROL_LOW && wb_sel_i == 4'hf
      |-> ##2 pins_o.input_disable[15:0] == $past(wb_dat_i[15:0], 2)) else $error("input forcing missing");
   a_async_powered: assert property (analog_o.async_clk_enable |-> analog_o.power_up)
      else $error("async clock on while idle");
   // Two-cycle view tolerates one cycle of skew between mask and read path
   a_read_masked: assert property ((port_read_o & pins_o.input_disable & $past(pins_o.input_disable)) == 24'h0)
      else $error("disabled pin reads high");
   a_sample_powered: assert property (analog_o.sample |-> analog_o.power_up)
      else $error("sampling while powered down");
   a_start_enabled: assert property ($rose(analog_o.power_up) |-> analog_o.channel != CH_DISABLED)
      else $error("start with channel disabled");
   c_write: cover property (req && wb_we_i);
   c_sample: cover property ($rose(analog_o.sample));
   c_done: cover property ($fell(analog_o.power_up));
endmodule
bind scc_sar_converter_control scc_sar_converter_control_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .analog_o(analog_o), .pins_o(pins_o),
   .port_read_o(port_read_o));
`default_nettype wire

//--- tb/scc_sar_converter_control_tb.sv
// Testbench: register-level tests of the converter control
`default_nettype none
module scc_sar_converter_control_tb import scc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_i, rst_i, cyc, stb, we, trig, ack, irq, cmp, stop;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat, q;
   logic [11:0] level, e;
   logic [2:0]  slow = 3'h0;
   scc_analog_t ana;
   scc_pins_t   pins;
   logic [23:0] pread;
   int          err_total, total_checks;
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // Slow stand-ins for the alternate and internal clocks
   always @(posedge clk_i) slow <= slow + 3'h1;
   scc_sar_converter_control uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .comparator_i(cmp),
      .alternate_clock_i(slow[1]), .internal_async_clock_i(slow[2]), .hw_trigger_input_i(trig),
      .stop_mode_i(stop), .port_pins_i(24'hff_ffff), .analog_o(ana), .pins_o(pins), .port_read_o(pread), .irq_o(irq));
   scc_core_model core (.clk_i(clk_i), .analog_i(ana), .level_i(level), .comparator_o(cmp));
   task automatic test_done;
      $display("checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 50) begin
         err_total++;
         test_done();
      end
      r = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0, r);
   endtask
   task automatic wait_done(output logic [31:0] s);
      int n;
      n = 0;
      do begin
         rd(ADR_STATUS, s);
         n++;
      end while (s[BUSY_BIT] === 1'b1 && n < 200);
      if (n >= 200) begin
         err_total++;
         test_done();
      end
   endtask
   // Rounding adds half an LSB and saturates at full scale
   function automatic logic [11:0] rnd(input logic [11:0] v, input logic [1:0] r);
      if (r == RES_12) return v;
      if (r == RES_10) return (v > 12'hffd) ? 12'h3ff : 12'((v + 12'h2) >> 2);
      return (v > 12'hff7) ? 12'h0ff : 12'((v + 12'h8) >> 4);
   endfunction
   logic [1:0]  rs[3] = '{RES_12, RES_10, RES_8};
   logic [11:0] cv[3] = '{12'h5a7, 12'h5a6, 12'h5a7};
   initial begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h0; sel = 4'h0; wdat = 32'h0;
      trig = 1'b0; stop = 1'b0; level = 12'h5a6; err_total = 0; total_checks = 0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_CTRL1, q); chk("ctrl1 reset", RST_CTRL1, q);
      rd(ADR_CTRL3, q); chk("ctrl3 reset", RST_ZERO, q);
      rd(8'h40, q); chk("unmapped", 32'h0, q);
      $display("test reset done");
      wr(ADR_PIN_CONTROL_LOW, 32'h0000_00a5);
      wr(ADR_PIN_CONTROL_HIGH, 32'h0000_0081);
      repeat (4) @(posedge clk_i);
      chk("output hiz", 32'h0081_00a5, {8'h0, pins.output_hiz});
      chk("pullup off", 32'h0081_00a5, {8'h0, pins.pullup_disable});
      chk("port read", 32'h007e_ff5a, {8'h0, pread});
      $display("test pins done");
      // Every source, bus and bus halved twice; bus halved with divide by 8 is the slowest
      for (int i = 0; i < 6; i++) begin
         level <= (i < 3) ? 12'h5a6 : 12'hffe;
         e = rnd((i < 3) ? 12'h5a6 : 12'hffe, rs[i % 3]);
         wr(ADR_CTRL3, {25'h0, (i == 1) ? 2'h3 : 2'h0, 1'b0, rs[i % 3], 2'(i)});
         wr(ADR_CTRL1, 32'h0000_0043);
         wait_done(q);
         chk("flag", 32'h1, {31'h0, q[FLAG_BIT]});
         chk("irq", 32'h1, {31'h0, irq});
         rd(ADR_RESULT_HIGH, q); chk("result high", {28'h0, e[11:8]}, q);
         rd(ADR_RESULT_LOW, q); chk("result low", {24'h0, e[7:0]}, q);
         chk("irq cleared", 32'h0, {31'h0, irq});
      end
      $display("test resolution done");
      level <= 12'h5a6;
      wr(ADR_CTRL3, {28'h0, RES_12, 2'h0});
      for (int i = 0; i < 3; i++) begin
         wr(ADR_COMPARE, {20'h0, cv[i]});
         wr(ADR_CTRL2, {30'h0, i != 0, 1'b1});
         wr(ADR_CTRL1, 32'h0000_0003);
         wait_done(q);
         chk("compare flag", {31'h0, i != 2}, {31'h0, q[FLAG_BIT]});
         chk("match", {31'h0, i != 2}, {31'h0, q[MATCH_BIT]});
      end
      $display("test compare done");
      wr(ADR_CTRL2, 32'h0000_0004);
      wr(ADR_CTRL1, 32'h0000_0003);
      rd(ADR_STATUS, q); chk("no soft start", 32'h0, {29'h0, q[2:0]});
      trig <= 1'b1;
      repeat (6) @(posedge clk_i);
      trig <= 1'b0;
      wait_done(q);
      chk("trigger flag", 32'h1, {31'h0, q[FLAG_BIT]});
      $display("test trigger done");
      wr(ADR_CTRL2, 32'h0);
      wr(ADR_CTRL3, 32'h0000_0017);
      stop <= 1'b1;
      wr(ADR_CTRL1, 32'h0000_0003);
      wait_done(q);
      chk("stop flag", 32'h1, {31'h0, q[FLAG_BIT]});
      wr(ADR_CTRL3, 32'h0000_0004);
      wr(ADR_CTRL1, 32'h0000_0003);
      wait_done(q);
      chk("abort flag", 32'h0, {31'h0, q[FLAG_BIT]});
      rd(ADR_RESULT_LOW, q);
      chk("kept low", 32'h0000_00a6, q);
      $display("test stop done");
      test_done();
   end
endmodule
`default_nettype wire
